// ==== hdl/irs_pkg.sv ====
/*
  Constants shared by the infrared pulse encoder/decoder: control register
  address, field positions, reset value and the bit timing in baud ticks.
  Assumes a baud tick that pulses sixteen times per serial bit.
*/
package irs_pkg;
  // Control register
  localparam logic [7:0] IRS_CTL_ADDR = 8'hBF;
  localparam logic [2:0] IRS_CTL_RESET = 3'h0;
  localparam int IRS_CTL_BITS = 3;
  localparam int IRS_EN_BIT = 0;
  localparam int IRS_RXEN_BIT = 1;
  localparam int IRS_LOOP_BIT = 2;
  // Bit timing in baud ticks
  localparam int IRS_TICKS_PER_BIT = 16;
  localparam int IRS_ZERO_LEAD = 7;
  localparam int IRS_ZERO_PULSE = 3;
  localparam int IRS_ZERO_TAIL = 6;
  localparam logic [3:0] IRS_PULSE_FIRST = 4'(IRS_ZERO_LEAD);
  localparam logic [3:0] IRS_PULSE_LAST = 4'(IRS_ZERO_LEAD + IRS_ZERO_PULSE - 1);
  localparam logic [3:0] IRS_BIT_LAST = 4'(IRS_ZERO_LEAD + IRS_ZERO_PULSE + IRS_ZERO_TAIL - 1);
  // Run of ones after which the decoder drops back to hunting
  localparam logic [3:0] IRS_IDLE_ONES = 4'hA;
endpackage

// ==== hdl/irs_bit_if.sv ====
/*
  Valid/ready channel for decoded serial bits between the decoder, the
  buffer and the output stage. Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface irs_bit_if #(parameter int W = 1);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== hdl/irs_pulse_dec.sv ====
/*
  Receive pulse decoder: finds the short low pulse in each bit period and
  hands one decoded bit per sixteen ticks to a valid/ready channel.
  Assumes the line input is already synchronised and idles high.
*/
`timescale 1ns/10ps
module irs_pulse_dec
  import irs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic tick,
  input wire logic line,
  irs_bit_if.src bits
);
  typedef struct packed {
    logic active;
    logic [3:0] cnt;
    logic sawLow;
    logic [3:0] ones;
    logic pend;
    logic pbit;
  } irs_dec_t;

  irs_dec_t st;
  irs_dec_t next_st;
  logic bitVal;

  assign bits.valid = st.pend;
  assign bits.data = st.pbit;

  // Phase is fixed by the first low sample, so only the first bit may jitter
  always_comb begin
    next_st = st;
    bitVal = !(st.sawLow || !line);
    if (st.pend && bits.ready) begin
      next_st.pend = 1'b0;
    end
    if (!enable) begin
      next_st = '0;
    end else if (tick && !st.active && !line) begin
      next_st.active = 1'b1;
      next_st.cnt = IRS_PULSE_FIRST + 4'h1;
      next_st.sawLow = 1'b1;
      next_st.ones = 4'h0;
    end else if (tick && st.active) begin
      next_st.cnt = st.cnt + 4'h1;
      next_st.sawLow = st.sawLow || !line;
      if (st.cnt == IRS_BIT_LAST) begin
        // A later bit overwrites a stalled one; the buffer keeps this rare
        next_st.pend = 1'b1;
        next_st.pbit = bitVal;
        next_st.sawLow = 1'b0;
        next_st.ones = bitVal ? st.ones + 4'h1 : 4'h0;
        if (bitVal && st.ones == IRS_IDLE_ONES - 4'h1) begin
          next_st.active = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  dec_one_bit_a: assert property (enable && tick && st.active && st.cnt == IRS_BIT_LAST && !st.sawLow && line
    |=> st.pend && st.pbit) else $error("High bit period not decoded as one");
  dec_zero_bit_a: assert property (enable && tick && st.active && st.cnt == IRS_BIT_LAST && st.sawLow
    |=> st.pend && !st.pbit) else $error("Low pulse not decoded as zero");
  dec_gate_off_a: assert property (!enable |=> !st.active && !st.pend)
    else $error("Decoder active while receive disabled");
  dec_zero_cv: cover property (st.pend && !st.pbit);
endmodule // irs_pulse_dec

// ==== hdl/irs_skid_buf.sv ====
/*
  Small FIFO on the decoded bit path so a stalled output stage loses no bit.
  Assumes both channels run on the same clock.
*/
`timescale 1ns/10ps
module irs_skid_buf #(
  parameter int W = 1,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  irs_bit_if.snk inp,
  irs_bit_if.src outp
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } irs_buf_t;

  irs_buf_t st;
  irs_buf_t next_st;
  logic push;
  logic pop;

  // Honest full and empty straight from the fill count
  assign inp.ready = st.cnt != CW'(DEPTH);
  assign outp.valid = st.cnt != '0;
  assign outp.data = st.mem[st.rp];

  always_comb begin
    next_st = st;
    push = inp.valid && inp.ready;
    pop = outp.valid && outp.ready;
    if (push) begin
      next_st.mem[st.wp] = inp.data;
      next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + PW'(1);
    end
    if (pop) begin
      next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + PW'(1);
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + CW'(1);
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  buf_no_over_a: assert property (st.cnt == CW'(DEPTH) && !outp.ready |=> st.cnt == CW'(DEPTH))
    else $error("Buffer count moved while full and stalled");
  buf_full_cv: cover property (st.cnt == CW'(DEPTH));
endmodule // irs_skid_buf

// ==== hdl/irs_infrared_endec.sv ====
/*
  Infrared serial encoder/decoder between the first UART and an external
  infrared transceiver, with its one control register.
  Assumes baudTick is a one-cycle pulse from the UART rate generator on clk,
  sixteen per bit, and uartTxd changes only on such ticks.
*/
// Notes on behaviour
// - A one bit keeps the pulse output low for all sixteen ticks.
// - A zero bit gives seven low ticks, three high, then six low.
// - Pulse timing follows UART serial output and baud tick, sixteen ticks per bit.
// - A receive line high for a whole bit period decodes as one.
// - Seven high, three low, six high ticks on receive decode as zero.
// - Decoder works only with receive enabled; its output drives the UART input.
// - Only the first decoded bit may jitter; later bits are exactly sixteen ticks.
// - Loopback inverts the pulse output and feeds it to the decoder input.
// - Control resets to zero; upper bits ignore writes and read zero.
// - Receive enable bit one gates the receive path into the UART.
// - Enable bit zero switches the whole encoder/decoder on or off.
`timescale 1ns/10ps
module irs_infrared_endec
  import irs_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic baudTick,
  input wire logic uartTxd,
  output logic uartRxd,
  input wire logic pulseRxIn,
  output logic pulseTxOut,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata
);

  typedef struct packed {
    logic [IRS_CTL_BITS-1:0] ctl;
    logic [7:0] rdata;
    logic txdPrev;
    logic [3:0] txPhase;
    logic txOut;
    logic [1:0] rxSync;
    logic rxOut;
    logic outBusy;
    logic [3:0] outCnt;
  } irs_top_t;

  irs_top_t st;
  irs_top_t next_st;

  logic endecOn;
  logic rxOn;
  logic loopOn;
  logic decLine;
  logic [3:0] nextPhase;
  logic hit;

  irs_bit_if #(.W(1)) decBits ();
  irs_bit_if #(.W(1)) outBits ();

  // Control fields
  assign endecOn = st.ctl[IRS_EN_BIT];
  assign rxOn = st.ctl[IRS_RXEN_BIT];
  assign loopOn = st.ctl[IRS_LOOP_BIT];
  assign hit = regAddr == IRS_CTL_ADDR;

  // In loopback the outside receive pin is ignored, so a stray transceiver
  // echo cannot corrupt the self test
  assign decLine = loopOn ? !st.txOut : st.rxSync[1];

  // Output stage takes a new bit only when the previous one is fully shown
  assign outBits.ready = !st.outBusy;

  // Decoder, enabled only with both the block and receive switched on
  irs_pulse_dec u_dec (
    .clk(clk),
    .reset(reset),
    .enable(endecOn && rxOn),
    .tick(baudTick),
    .line(decLine),
    .bits(decBits.src)
  );

  // Buffer between decoder and output stage
  irs_skid_buf #(.W(1), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .reset(reset),
    .inp(decBits.snk),
    .outp(outBits.src)
  );

  // Next-state logic for register, encoder, pin synchroniser and output stage
  always_comb begin
    next_st = st;

    // Register write; unused upper bits are simply never stored
    if (regWr && hit) begin
      next_st.ctl = regWdata[IRS_CTL_BITS-1:0];
    end

    // Read data stands one cycle after the read strobe; unmapped reads give zero
    next_st.rdata = 8'h00;
    if (regRd && hit) begin
      next_st.rdata = {{(8 - IRS_CTL_BITS){1'b0}}, st.ctl};
    end

    // Two flip-flops before the receive pin is used
    next_st.rxSync = {st.rxSync[0], pulseRxIn};

    // Encoder phase restarts on every UART edge so it stays bit aligned
    nextPhase = st.txPhase + 4'h1;
    if (uartTxd != st.txdPrev) begin
      nextPhase = 4'h0;
    end
    if (baudTick) begin
      next_st.txdPrev = uartTxd;
      next_st.txPhase = nextPhase;
      // High only inside the pulse window of a zero bit
      next_st.txOut = !uartTxd && nextPhase >= IRS_PULSE_FIRST
        && nextPhase <= IRS_PULSE_LAST;
    end

    // Output stage shows each decoded bit for exactly sixteen ticks
    if (outBits.valid && !st.outBusy) begin
      next_st.outBusy = 1'b1;
      next_st.outCnt = 4'h0;
      next_st.rxOut = outBits.data;
    end else if (st.outBusy && baudTick) begin
      next_st.outCnt = st.outCnt + 4'h1;
      if (st.outCnt == IRS_BIT_LAST) begin
        next_st.outBusy = 1'b0;
      end
    end else if (!st.outBusy && baudTick) begin
      // Back to idle only after a whole tick with nothing to show, so the next
      // bit, which lands two clocks after the drop, follows without a gap;
      // this needs ticks at least two clocks apart
      next_st.rxOut = 1'b1;
    end

    // Switched off: pins rest, receive path quiet
    if (!endecOn) begin
      next_st.txOut = 1'b0;
      next_st.rxOut = 1'b1;
      next_st.outBusy = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.ctl <= IRS_CTL_RESET;
      st.rxSync <= 2'b11;
      st.txdPrev <= 1'b1;
      st.rxOut <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Pins and read data come straight from flip-flops
  assign pulseTxOut = st.txOut;
  assign uartRxd = st.rxOut;
  assign regRdata = st.rdata;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // A pulse never appears during a one bit
  tx_one_low_a: assert property (st.txOut |-> !st.txdPrev)
    else $error("Pulse output high during a one bit");

  // Pulse starts at tick seven of the bit
  tx_pulse_start_a: assert property ($rose(st.txOut) |-> st.txPhase == IRS_PULSE_FIRST)
    else $error("Pulse did not start after seven low ticks");

  // Pulse ends after three ticks while the zero bit continues
  tx_pulse_end_a: assert property ($fell(st.txOut) && endecOn && !st.txdPrev && st.txPhase != 4'h0
    |-> st.txPhase == IRS_PULSE_LAST + 4'h1) else $error("Pulse not three ticks long");

  // UART edge restarts the phase at the next tick
  tx_phase_sync_a: assert property (baudTick && uartTxd != st.txdPrev |=> st.txPhase == 4'h0)
    else $error("Encoder phase not aligned to UART edge");

  // Each shown bit holds for sixteen ticks exactly
  rx_bit_width_a: assert property (st.outBusy && endecOn && baudTick && st.outCnt == IRS_BIT_LAST
    |=> !st.outBusy) else $error("Decoded bit not sixteen ticks wide");

  // Shown bit stays stable while it is held
  rx_bit_hold_a: assert property (st.outBusy && $past(st.outBusy) && endecOn |-> $stable(st.rxOut))
    else $error("UART input changed inside a bit");

  // Disabled block rests its outputs
  idle_levels_a: assert property (!endecOn |=> !st.txOut && st.rxOut)
    else $error("Outputs not idle while disabled");

  // Control read returns stored bits with zero above
  ctl_read_a: assert property (regRd && hit |=> regRdata == {5'h00, $past(st.ctl)})
    else $error("Control read data wrong");

  // Upper bits never stored
  ctl_write_a: assert property (regWr && hit |=> st.ctl == $past(regWdata[2:0]))
    else $error("Control write not taken");

  // Loopback feeds the inverted pulse into the decoder
  loop_route_a: assert property (loopOn |-> decLine == !pulseTxOut)
    else $error("Loopback path not inverted pulse output");

  // Main scenarios
  tx_zero_cv: cover property ($rose(st.txOut) ##3 $fell(st.txOut));
  loop_rx_cv: cover property (loopOn && rxOn && endecOn && st.outBusy && !st.rxOut);
  rx_bits_cv: cover property ($fell(st.outBusy) ##1 st.outBusy);

endmodule // irs_infrared_endec

// ==== test/irs_xcvr_model.sv ====
/*
  Behavioural model of the infrared transceiver that feeds the receive pin
  and can echo the transmit pulses back. Assumes the bench baud tick,
  sixteen ticks per serial bit.
*/
`timescale 1ns/10ps
module irs_xcvr_model (
  input wire logic clk,
  input wire logic baudTick,
  input wire logic pulseTxOut,
  output logic pulseRxIn
);
  // The pin is pulled up, so it rests high outside frames
  initial pulseRxIn = 1'b1;

  // Sends n bits LSB first; a zero is a three-tick low pulse after seven high ticks
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      for (int p = 0; p < 16; p++) begin
        @(posedge clk iff baudTick);
        pulseRxIn <= (bits[i] == 1'b0 && p >= 7 && p <= 9) ? 1'b0 : 1'b1;
      end
    end
  endtask

  // Optical echo for n bits: emitted light shows up as a low on the receiver
  task automatic echo(input int n);
    int t;
    t = 0;
    while (t < 16 * n) begin
      @(posedge clk);
      pulseRxIn <= !pulseTxOut;
      if (baudTick) begin
        t++;
      end
    end
  endtask
endmodule // irs_xcvr_model

// ==== test/test_infrared_serial_endec.sv ====
/*
  Self-checking bench for the infrared encoder/decoder: register access,
  pulse encoding, decoding, gating and internal loopback.
  Assumes the transceiver model file and the design files are compiled first.
*/
`timescale 1ns/10ps
module test_infrared_serial_endec;
  import irs_pkg::*;
  localparam int TP = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic baudTick = 1'b0;
  logic uartTxd = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic uartRxd;
  logic pulseRxIn;
  logic pulseTxOut;
  logic [7:0] regRdata;
  logic rxLow;
  logic txHigh;
  logic [7:0] gate [2] = '{8'h01, 8'h02};
  int tickCnt = 0;
  int failures = 0;
  int comparisons = 0;

  // No modem status lines reach this block, so the modem interrupt stays quiet
  irs_infrared_endec #(.BUF_DEPTH(2)) dut (.clk(clk), .reset(reset), .baudTick(baudTick), .uartTxd(uartTxd),
    .uartRxd(uartRxd), .pulseRxIn(pulseRxIn), .pulseTxOut(pulseTxOut), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  // Both pulse pins wired straight through, as with their port pins in alternate mode
  irs_xcvr_model xcvr (.clk(clk), .baudTick(baudTick), .pulseTxOut(pulseTxOut), .pulseRxIn(pulseRxIn));

  always #50 clk = ~clk;

  // Stands in for the running UART rate generator: one tick every TP clocks
  always @(posedge clk) begin
    tickCnt <= (tickCnt == TP - 1) ? 0 : tickCnt + 1;
    baudTick <= (tickCnt == TP - 1);
  end

  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, zero afterwards
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    chk8("read data", exp, regRdata);
    @(posedge clk);
    chk8("read data after", 8'h00, regRdata);
  endtask

  // Drives UART bits on tick cycles; optionally checks the pulse after each tick
  task automatic tx_bits(input logic [15:0] bits, input int n, input bit chkOn);
    for (int i = 0; i < n; i++) begin
      for (int p = 0; p < 16; p++) begin
        @(posedge clk iff tickCnt == TP - 1);
        uartTxd <= bits[i];
        if (chkOn) begin
          repeat (3) @(posedge clk);
          chk1("pulse out", !bits[i] && p >= 7 && p <= 9, pulseTxOut);
        end
      end
    end
    @(posedge clk iff tickCnt == TP - 1);
    uartTxd <= 1'b1;
  endtask

  // Finds the first fall, then samples near both ends of each sixteen-tick bit
  task automatic rx_expect(input logic [15:0] bits, input int n);
    int w;
    w = 0;
    while (uartRxd !== 1'b0 && w < 3000) begin
      @(posedge clk);
      w++;
    end
    chk1("rx start", 1'b0, uartRxd);
    for (int i = 0; i < n; i++) begin
      repeat (TP) @(posedge clk);
      chk1("rx bit head", bits[i], uartRxd);
      // Last cycle of the bit, where a gap before the next bit would show
      repeat (15 * TP - 1) @(posedge clk);
      chk1("rx bit tail", bits[i], uartRxd);
      @(posedge clk);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out;
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk1("tx idle", 1'b0, pulseTxOut);
    chk1("rx idle", 1'b1, uartRxd);
    reg_chk(IRS_CTL_ADDR, 8'h00);
    reg_wr(IRS_CTL_ADDR, 8'hFF);
    reg_chk(IRS_CTL_ADDR, 8'h07);
    reg_wr(8'hBE, 8'h00);
    reg_chk(IRS_CTL_ADDR, 8'h07);
    reg_chk(8'hBE, 8'h00);
    // Transmit with receive off keeps the link half duplex
    reg_wr(IRS_CTL_ADDR, 8'h01);
    tx_bits(16'h0004, 4, 1'b1);
    reg_wr(IRS_CTL_ADDR, 8'h03);
    fork
      xcvr.send(16'h0012, 5);
      rx_expect(16'h0012, 5);
    join
    // Receive off, then whole block off: pin traffic must not reach the UART
    foreach (gate[k]) begin
      reg_wr(IRS_CTL_ADDR, gate[k]);
      rxLow = 1'b0;
      txHigh = 1'b0;
      fork
        xcvr.send(16'h0000, 3);
        tx_bits(16'h0000, 3, 1'b0);
        repeat (3 * 16 * TP) begin
          @(posedge clk);
          rxLow |= (uartRxd !== 1'b1);
          txHigh |= (pulseTxOut === 1'b1);
        end
      join
      chk1("rx gated", 1'b0, rxLow);
      chk1("tx gated", gate[k][0], txHigh);
    end
    // Loopback must follow the encoder and ignore zeros arriving on the pin
    reg_wr(IRS_CTL_ADDR, 8'h07);
    fork
      tx_bits(16'h001A, 5, 1'b0);
      xcvr.send(16'h0000, 5);
      rx_expect(16'h001A, 5);
    join
    // External loopback: the transceiver echoes our own pulses while receive stays on
    reg_wr(IRS_CTL_ADDR, 8'h01);
    reg_wr(IRS_CTL_ADDR, 8'h03);
    fork
      tx_bits(16'h0016, 5, 1'b0);
      xcvr.echo(6);
      rx_expect(16'h0016, 5);
    join
    close_out;
  end
endmodule // test_infrared_serial_endec
